// ---- design/lbc_pkg.sv ----
// constants and types shared by the local bus control and decode block
package lbc_pkg;
  // register block layout
  localparam logic [7:0] OFS_UPPER_SEL = 8'hA0;
  localparam logic [7:0] OFS_RELOC = 8'hFE;
  localparam logic [15:0] RELOC_RST = 16'h20FF;
  localparam logic [15:0] UPPER_SEL_RST = 16'hFFFB;
  localparam logic [15:0] UPPER_CMP_MASK = 16'hFFC0;
  localparam int RELOC_MEM_BIT = 12;
  localparam int RELOC_SLAVE_BIT = 14;
  localparam int RELOC_ESC_BIT = 15;
  localparam int BASE_W = 12;
  // ready field
  localparam int WAIT_IGNORE_BIT = 2;
  localparam logic [1:0] WAIT_MAX = 2'h3;
  // pin codes
  localparam logic [2:0] STATUS_PASSIVE = 3'h7;
  localparam logic [3:0] IO_TOP_ZERO = 4'h0;
  localparam logic [15:0] NO_REG_DATA = 16'h0000;

  typedef enum logic [2:0] {
    ST_IDLE = 3'b000,
    ST_T1 = 3'b001,
    ST_T2 = 3'b010,
    ST_T3 = 3'b011,
    ST_TW = 3'b100,
    ST_T4 = 3'b101,
    ST_HOLD = 3'b110,
    ST_RST = 3'b111
  } busState_e;
endpackage

// ---- design/pin_sync.sv ----
// two-flop synchroniser for inputs arriving from the pins
module pin_sync #(
  parameter int W = 1
) (
  // clock and reset
  input wire logic core_clk,
  input wire logic rst,
  // data
  input wire logic [W-1:0] din,
  output logic [W-1:0] dout
);
  logic [W-1:0] meta_q;

  // first stage feeds only the second stage
  always_ff @(posedge core_clk) begin
    if (rst) begin
      meta_q <= '0;
      dout <= '0;
    end else begin
      meta_q <= din;
      dout <= meta_q;
    end
  end
endmodule

// ---- design/wait_gen.sv ----
// programmable wait state counter merged with external ready
module wait_gen
  import lbc_pkg::*;
(
  // clock and reset
  input wire logic core_clk,
  input wire logic rst,
  // cycle context
  input wire logic waitActive,
  input wire logic regionHit,
  input wire logic internalHit,
  input wire logic [2:0] waitModeField,
  input wire logic extReady,
  // result
  output logic cycleReady
);
  logic [1:0] cnt_q;
  logic [1:0] cnt_d;
  logic intReady;

  // count wait cycles, saturating so long external waits never wrap
  always_comb begin
    cnt_d = 2'h0;
    if (waitActive && !rst) begin
      cnt_d = (cnt_q == WAIT_MAX) ? cnt_q : 2'(cnt_q + 2'h1);
    end
  end

  always_ff @(posedge core_clk) begin
    cnt_q <= cnt_d;
  end

  // internal and external ready run in parallel, not in series
  always_comb begin
    intReady = (cnt_q >= waitModeField[1:0]);
    if (internalHit) begin
      cycleReady = 1'b1;
    end else if (regionHit) begin
      cycleReady = waitModeField[WAIT_IGNORE_BIT] ? intReady
                 : (intReady && extReady);
    end else begin
      cycleReady = extReady;
    end
  end

  a_ignore_ext: assert property (@(posedge core_clk) disable iff (rst)
    waitActive && internalHit |-> cycleReady)
    else $error("internal cycle waited on external ready");
  a_wait_count: assert property (@(posedge core_clk) disable iff (rst)
    waitActive && regionHit && !internalHit
      && cnt_q < waitModeField[1:0] |-> !cycleReady)
    else $error("programmed wait states cut short");
endmodule

// ---- design/local_bus_control_and_decode.sv ----
// local bus controller, register block decode and upper memory select
module local_bus_control_and_decode
  import lbc_pkg::*;
(
  // clock and reset
  input wire logic core_clk,
  input wire logic rst,
  // core cycle requests
  input wire logic reqValid,
  input wire logic [19:0] reqAddr,
  input wire logic reqWrite,
  input wire logic reqIo,
  input wire logic reqHighByte,
  input wire logic [2:0] reqStatus,
  input wire logic [15:0] reqData,
  input wire logic lockSeq,
  input wire logic dmaBusy,
  // core answers and control bits
  output logic doneValid,
  output logic [15:0] doneData,
  output logic slaveInterruptMode,
  output logic escapeTrap,
  // bus exchange
  input wire logic holdReq,
  output logic busGrantOut,
  // strobes and status, one enable for the group
  output logic ale,
  output logic readStrobeN,
  output logic writeStrobeN,
  output logic transceiverEnableN,
  output logic [2:0] cycleStatusLines,
  output logic lockN,
  output logic ctrlOe,
  // address and data
  input wire logic [15:0] muxedAddrDataIn,
  output logic [15:0] muxedAddrDataOut,
  output logic adOe,
  output logic [3:0] upperAddress,
  output logic highByteEnableN,
  output logic transferDirection,
  output logic upperOe,
  // ready and select
  input wire logic syncReadyIn,
  input wire logic asyncReadyIn,
  output logic upperMemSelectN
);
  busState_e state_q, stateD;
  logic [19:0] cycAddr_q, cycAddrD;
  logic [15:0] cycData_q, cycDataD;
  logic [2:0] cycStatus_q, cycStatusD;
  logic cycWrite_q, cycWriteD, cycIo_q, cycIoD;
  logic cycHigh_q, cycHighD, cycLock_q, cycLockD;
  logic ucsHit_q, ucsHitD;
  logic [15:0] reloc_q, relocD, upperCfg_q, upperCfgD;
  logic [15:0] regRead, adS;
  logic holdS, syncRdyS, asyncRdyS;
  logic intHit, cycleReady, waitActive, readyEdge, regWrite;
  logic [7:0] regOfs;
  logic aleD, rdND, wrND, denND, lockND, ctrlOeD, adOeD;
  logic upperOeD, bheND, dtrD, ucsND, grantD, doneD;
  logic [2:0] statusD;
  logic [3:0] upperD;
  logic [15:0] adOutD, doneDataD;

  // every pin input is synchronised before use
  pin_sync #(.W(19)) u_sync (
    .core_clk(core_clk),
    .rst(rst),
    .din({holdReq, syncReadyIn, asyncReadyIn, muxedAddrDataIn}),
    .dout({holdS, syncRdyS, asyncRdyS, adS})
  );

  assign waitActive = (state_q == ST_T3) || (state_q == ST_TW);
  assign readyEdge = waitActive && cycleReady;

  wait_gen u_wait (
    .core_clk(core_clk),
    .rst(rst),
    .waitActive(waitActive),
    .regionHit(ucsHit_q),
    .internalHit(intHit),
    .waitModeField(upperCfg_q[2:0]),
    .extReady(syncRdyS || asyncRdyS),
    .cycleReady(cycleReady)
  );

  // register block hit, base on a 256-byte boundary
  always_comb begin
    if (cycIo_q) begin
      intHit = !reloc_q[RELOC_MEM_BIT] && cycAddr_q[19:16] == IO_TOP_ZERO
             && cycAddr_q[15:8] == reloc_q[7:0];
    end else begin
      intHit = reloc_q[RELOC_MEM_BIT]
             && cycAddr_q[19:8] == reloc_q[BASE_W-1:0];
    end
  end

  // bus cycle sequencer; hold only checked between cycles
  always_comb begin
    stateD = state_q;
    cycAddrD = cycAddr_q;
    cycDataD = cycData_q;
    cycStatusD = cycStatus_q;
    cycWriteD = cycWrite_q;
    cycIoD = cycIo_q;
    cycHighD = cycHigh_q;
    cycLockD = cycLock_q;
    ucsHitD = ucsHit_q;
    unique case (state_q)
      ST_IDLE: begin
        if (holdS && !lockSeq && !dmaBusy) begin
          stateD = ST_HOLD;
        end else if (reqValid) begin
          stateD = ST_T1;
          cycAddrD = reqAddr;
          cycDataD = reqData;
          cycStatusD = reqStatus;
          cycWriteD = reqWrite;
          cycIoD = reqIo;
          cycHighD = reqHighByte;
          cycLockD = lockSeq;
          // latched once so the select cannot move mid cycle
          ucsHitD = !reqIo
                  && reqAddr[19:4] >= (upperCfg_q & UPPER_CMP_MASK);
        end
      end
      ST_T1: stateD = ST_T2;
      ST_T2: stateD = ST_T3;
      ST_T3, ST_TW: stateD = cycleReady ? ST_T4 : ST_TW;
      ST_T4: stateD = ST_IDLE;
      ST_HOLD: begin
        if (!holdS) begin
          stateD = ST_IDLE;
        end
      end
      ST_RST: stateD = ST_IDLE;
    endcase
    if (rst) begin
      stateD = ST_RST;
      ucsHitD = 1'b0;
      cycLockD = 1'b0;
    end
  end

  always_ff @(posedge core_clk) begin
    state_q <= stateD;
    cycAddr_q <= cycAddrD;
    cycData_q <= cycDataD;
    cycStatus_q <= cycStatusD;
    cycWrite_q <= cycWriteD;
    cycIo_q <= cycIoD;
    cycHigh_q <= cycHighD;
    cycLock_q <= cycLockD;
    ucsHit_q <= ucsHitD;
  end

  // register file, written at the ready edge with byte lanes
  assign regOfs = {cycAddr_q[7:1], 1'b0};
  assign regWrite = readyEdge && intHit && cycWrite_q;

  always_comb begin
    relocD = reloc_q;
    upperCfgD = upperCfg_q;
    if (regOfs == OFS_RELOC) begin
      regRead = reloc_q;
    end else if (regOfs == OFS_UPPER_SEL) begin
      regRead = upperCfg_q;
    end else begin
      regRead = NO_REG_DATA;
    end
    if (regWrite && regOfs == OFS_RELOC) begin
      if (!cycAddr_q[0]) relocD[7:0] = cycData_q[7:0];
      if (cycHigh_q) relocD[15:8] = cycData_q[15:8];
    end
    if (regWrite && regOfs == OFS_UPPER_SEL) begin
      if (!cycAddr_q[0]) upperCfgD[7:0] = cycData_q[7:0];
      if (cycHigh_q) upperCfgD[15:8] = cycData_q[15:8];
    end
    if (rst) begin
      relocD = RELOC_RST;
      upperCfgD = UPPER_SEL_RST;
    end
  end

  always_ff @(posedge core_clk) begin
    reloc_q <= relocD;
    upperCfg_q <= upperCfgD;
  end

  // pin values follow the next state so every output is a flop
  always_comb begin
    aleD = 1'b0;
    rdND = 1'b1;
    wrND = 1'b1;
    denND = 1'b1;
    statusD = STATUS_PASSIVE;
    lockND = 1'b1;
    ctrlOeD = 1'b1;
    adOutD = cycAddrD[15:0];
    adOeD = 1'b0;
    upperD = cycAddrD[19:16];
    bheND = !cycHighD;
    dtrD = cycWriteD;
    upperOeD = 1'b0;
    ucsND = 1'b1;
    grantD = 1'b0;
    doneD = (stateD == ST_T4);
    // internal cycles never look at the data pins
    doneDataD = readyEdge ? (intHit ? regRead : adS) : doneData;
    unique case (stateD)
      ST_IDLE: ;
      ST_T1: begin
        aleD = 1'b1;
        adOeD = 1'b1;
        upperOeD = 1'b1;
        statusD = cycStatusD;
        lockND = !cycLockD;
        ucsND = !ucsHitD;
      end
      ST_T2, ST_T3, ST_TW: begin
        rdND = cycWriteD;
        wrND = !cycWriteD;
        denND = 1'b0;
        adOutD = cycDataD;
        adOeD = cycWriteD;
        upperOeD = 1'b1;
        dtrD = cycWriteD;
        statusD = cycStatusD;
        lockND = !cycLockD;
        ucsND = !ucsHitD;
      end
      ST_T4: begin
        denND = 1'b0;
        adOutD = cycDataD;
        adOeD = cycWriteD;
        upperOeD = 1'b1;
        lockND = !cycLockD;
        ucsND = !ucsHitD;
      end
      ST_HOLD: begin
        ctrlOeD = 1'b0;
        grantD = 1'b1;
      end
      ST_RST: ;
    endcase
    // one clock of float after release; state_q still shows reset then
    if (state_q == ST_RST) begin
      ctrlOeD = 1'b0;
    end
    if (rst) begin
      ctrlOeD = 1'b1;
      doneDataD = NO_REG_DATA;
      doneD = 1'b0;
    end
  end

  always_ff @(posedge core_clk) begin
    ale <= aleD;
    readStrobeN <= rdND;
    writeStrobeN <= wrND;
    transceiverEnableN <= denND;
    cycleStatusLines <= statusD;
    lockN <= lockND;
    ctrlOe <= ctrlOeD;
    muxedAddrDataOut <= adOutD;
    adOe <= adOeD;
    upperAddress <= upperD;
    highByteEnableN <= bheND;
    transferDirection <= dtrD;
    upperOe <= upperOeD;
    upperMemSelectN <= ucsND;
    busGrantOut <= grantD;
    doneValid <= doneD;
    doneData <= doneDataD;
    slaveInterruptMode <= relocD[RELOC_SLAVE_BIT];
    escapeTrap <= relocD[RELOC_ESC_BIT];
  end

  default clocking cb @(posedge core_clk); endclocking

  sequence sCycStart;
    state_q == ST_T1 && ucsHit_q;
  endsequence
  sequence sSelHeld;
    (!upperMemSelectN)[*4];
  endsequence
  sequence sResetPulse;
    rst;
  endsequence

  a_ale_in_t1: assert property (disable iff (rst)
    state_q == ST_T1 |-> ale && adOe && ctrlOe)
    else $error("latch strobe missing in first state");
  a_den_in_cycle: assert property (disable iff (rst)
    state_q == ST_T2 |-> !transceiverEnableN ##1 !transceiverEnableN)
    else $error("transceiver enable not low in cycle");
  a_dir_by_write: assert property (disable iff (rst)
    state_q == ST_T2 |-> transferDirection == cycWrite_q
      && readStrobeN == cycWrite_q && writeStrobeN != cycWrite_q)
    else $error("direction or strobe wrong for cycle");
  a_hold_float: assert property (disable iff (rst)
    busGrantOut |-> !ctrlOe && !adOe && !upperOe)
    else $error("pins driven while bus granted");
  a_hold_first: assert property (disable iff (rst)
    state_q == ST_IDLE && holdS && !dmaBusy && !lockSeq
      |=> busGrantOut && !ale)
    else $error("bus request not granted ahead of cycle");
  a_lock_defer: assert property (disable iff (rst)
    lockSeq && !busGrantOut |=> !busGrantOut)
    else $error("grant given during locked sequence");
  a_reset_drive: assert property (
    sResetPulse |=> ctrlOe && readStrobeN && writeStrobeN
      && transceiverEnableN && lockN
      && cycleStatusLines == STATUS_PASSIVE)
    else $error("reset drive pattern wrong");
  a_reset_float: assert property (sResetPulse ##1 !rst
    |=> !ctrlOe && !adOe && !upperOe && !ale && !busGrantOut)
    else $error("pins not floated after reset");
  a_reloc_reset: assert property (
    sResetPulse |=> reloc_q == RELOC_RST && upperCfg_q == UPPER_SEL_RST)
    else $error("register reset values wrong");
  a_sel_held: assert property (disable iff (rst)
    sCycStart |-> sSelHeld)
    else $error("upper select dropped inside cycle");
endmodule

// ---- bench/far_side_model.sv ----
// external memory and ready source on the far side of the local bus
module far_side_model (
  // clock and bus pins
  input wire logic core_clk,
  input wire logic ale,
  input wire logic readStrobeN,
  input wire logic transferDirection,
  input wire logic [15:0] muxedAddrDataOut,
  // stall control
  input wire logic [7:0] readyDelay,
  input wire logic useAsync,
  // answers
  output logic [15:0] muxedAddrDataIn,
  output logic syncReadyIn,
  output logic asyncReadyIn
);
  timeunit 1ns;
  timeprecision 100ps;
  logic [15:0] addr_q = 16'h0000;
  logic [7:0] wait_q = 8'h00;
  logic drive_q = 1'b0;
  logic saw_q = 1'b0;
  logic readyNow;
  // latch address at the strobe, serve reads until the strobe rises
  always @(posedge core_clk) begin
    if (ale === 1'b1) begin
      addr_q <= muxedAddrDataOut;
      wait_q <= readyDelay;
      drive_q <= (transferDirection === 1'b0);
      saw_q <= 1'b0;
    end else begin
      if (wait_q != 8'h00) wait_q <= wait_q - 8'h01;
      if (readStrobeN === 1'b0) saw_q <= 1'b1;
      else if (saw_q) drive_q <= 1'b0;
    end
  end
  // answers from the latch strobe on, since the core sees pins two flops
  // late; a released bus shows the inverse, so stale data never passes
  assign muxedAddrDataIn = (ale === 1'b1) ? muxedAddrDataOut ^ 16'hA5C3
      : drive_q ? addr_q ^ 16'hA5C3 : ~(addr_q ^ 16'hA5C3);
  // a slow device pulls ready low as soon as its address shows
  assign readyNow = (ale === 1'b1) ? (readyDelay == 8'h00)
      : (wait_q == 8'h00);
  assign syncReadyIn = !useAsync && readyNow;
  assign asyncReadyIn = useAsync && readyNow;
endmodule

// ---- bench/test_local_bus_control_and_decode.sv ----
// bench: bus cycles, register block, upper select and bus exchange
module test_local_bus_control_and_decode import lbc_pkg::*;;
  timeunit 1ns;
  timeprecision 100ps;
  logic core_clk;
  logic rst = 1'b1;
  logic reqValid = 1'b0, reqWrite = 1'b0, reqIo = 1'b0;
  logic reqHighByte = 1'b1, lockSeq = 1'b0, dmaBusy = 1'b0;
  logic holdReq = 1'b0, useAsync = 1'b0;
  logic [19:0] reqAddr = 20'h00000;
  logic [2:0] reqStatus = 3'h5;
  logic [15:0] reqData = 16'h0000;
  logic [7:0] readyDelay = 8'h00;
  logic doneValid, slaveInterruptMode, escapeTrap, busGrantOut, ale;
  logic readStrobeN, writeStrobeN, transceiverEnableN, lockN, ctrlOe;
  logic adOe, highByteEnableN, transferDirection, upperOe;
  logic syncReadyIn, asyncReadyIn, upperMemSelectN;
  logic [15:0] doneData, muxedAddrDataIn, muxedAddrDataOut, rd, t2Ad;
  logic [2:0] cycleStatusLines;
  logic [3:0] upperAddress;
  logic [24:0] t1;
  logic [5:0] t2, t2Io;
  int badCount = 0;
  int nTests = 0;
  int cyc, k, j;

  local_bus_control_and_decode u_dut (
    .core_clk, .rst, .reqValid, .reqAddr, .reqWrite, .reqIo, .reqHighByte,
    .reqStatus, .reqData, .lockSeq, .dmaBusy, .doneValid, .doneData,
    .slaveInterruptMode, .escapeTrap, .holdReq, .busGrantOut, .ale,
    .readStrobeN, .writeStrobeN, .transceiverEnableN, .cycleStatusLines,
    .lockN, .ctrlOe, .muxedAddrDataIn, .muxedAddrDataOut, .adOe,
    .upperAddress, .highByteEnableN, .transferDirection, .upperOe,
    .syncReadyIn, .asyncReadyIn, .upperMemSelectN
  );

  far_side_model u_far (
    .core_clk, .ale, .readStrobeN, .transferDirection, .muxedAddrDataOut,
    .readyDelay, .useAsync, .muxedAddrDataIn, .syncReadyIn, .asyncReadyIn
  );

  // 40 MHz core clock
  initial begin
    core_clk = 1'b0;
    forever #12.5 core_clk = ~core_clk;
  end

  task automatic giveVerdict();
    if (badCount == 0 && nTests > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask

  task automatic check(input string what, input logic [31:0] seen,
      input logic [31:0] exp);
    nTests++;
    if (seen !== exp) begin
      badCount++;
      $display("[FAIL] %s expected %h seen %h", what, exp, seen);
    end
  endtask

  // one core request, held until the done pulse is sampled at an edge
  task automatic cycle(input logic [19:0] a, input logic wr,
      input logic io, input logic [15:0] d);
    int n;
    @(posedge core_clk);
    reqAddr <= a;
    reqWrite <= wr;
    reqIo <= io;
    reqData <= d;
    reqValid <= 1'b1;
    for (n = 1; n <= 40; n++) begin
      @(posedge core_clk);
      if (doneValid === 1'b1) break;
      #1;
      if (n == 1) t1 = {ale, upperMemSelectN, cycleStatusLines,
          upperAddress, muxedAddrDataOut};
      if (n == 2) t2 = {readStrobeN, writeStrobeN, transceiverEnableN,
          transferDirection, adOe, upperMemSelectN};
      if (n == 2) t2Ad = muxedAddrDataOut;
    end
    cyc = n;
    rd = doneData;
    reqValid <= 1'b0;
    if (n > 40) begin
      badCount++;
      giveVerdict();
    end
  endtask

  // bounded wait for the grant output to reach a level
  task automatic waitGrant(input logic v);
    for (k = 1; k <= 30; k++) begin
      @(posedge core_clk);
      if (busGrantOut === v) break;
    end
    if (k > 30) begin
      badCount++;
      giveVerdict();
    end
  endtask

  // main sequence
  initial begin
    repeat (9) @(posedge core_clk);
    #1;
    check("rst ctrl", {ctrlOe, readStrobeN, writeStrobeN}, 3'h7);
    check("rst den", transceiverEnableN, 1'b1);
    check("rst status", {cycleStatusLines, lockN}, 4'hF);
    check("rst float", {adOe, upperOe, ale, busGrantOut}, 4'h0);
    check("rst select", upperMemSelectN, 1'b1);
    @(posedge core_clk);
    rst <= 1'b0;
    @(posedge core_clk);
    #1;
    check("float after", {ctrlOe, ale}, 2'h0);
    @(posedge core_clk);
    #1;
    check("idle", {ctrlOe, cycleStatusLines}, {1'b1, STATUS_PASSIVE});
    cycle(20'h0FFFE, 1'b0, 1'b1, 16'h0000);
    check("reloc rst", rd, RELOC_RST);
    check("reg len", cyc, 5);
    check("t1", t1, {2'b11, 3'h5, 4'h0, 16'hFFFE});
    check("t2 read", t2, 6'b010001);
    check("hi byte", highByteEnableN, 1'b0);
    readyDelay <= 8'd30;
    useAsync <= 1'b1;
    cycle(20'h0FFA0, 1'b0, 1'b1, 16'h0000);
    check("upper rst", rd, UPPER_SEL_RST);
    check("reg no wait", cyc, 5);
    readyDelay <= 8'd0;
    useAsync <= 1'b0;
    cycle(20'h0FF10, 1'b0, 1'b1, 16'h0000);
    check("unmapped", rd, NO_REG_DATA);
    cycle(20'h0FFA0, 1'b1, 1'b1, 16'hFFB8);
    check("t2 write", t2, 6'b100111);
    check("write data", t2Ad, 16'hFFB8);
    cycle(20'h0FFA0, 1'b0, 1'b1, 16'h0000);
    check("upper rd", rd, 16'hFFB8);
    cycle(20'hFF800, 1'b0, 1'b0, 16'h0000);
    check("sel t1", t1[23], 1'b0);
    check("sel t2", t2[0], 1'b0);
    check("ext data", rd, 16'hF800 ^ 16'hA5C3);
    check("no wait", cyc, 5);
    cycle(20'hFF7FE, 1'b0, 1'b0, 16'h0000);
    check("sel below", t1[23], 1'b1);
    cycle(20'h01234, 1'b0, 1'b1, 16'h0000);
    t2Io = t2;
    cycle(20'h01234, 1'b0, 1'b0, 16'h0000);
    check("no space pin", t2, t2Io);
    cycle(20'h0FFA0, 1'b1, 1'b1, 16'hFFBF);
    readyDelay <= 8'd30;
    cycle(20'hFF800, 1'b0, 1'b0, 16'h0000);
    check("wait ignore", cyc, 8);
    check("wait data", rd, 16'hF800 ^ 16'hA5C3);
    cycle(20'h0FFA0, 1'b1, 1'b1, 16'hFFBB);
    readyDelay <= 8'd5;
    cycle(20'hFF800, 1'b0, 1'b0, 16'h0000);
    check("wait plus ext", cyc > 8, 1'b1);
    readyDelay <= 8'd0;
    cycle(20'hFF800, 1'b0, 1'b0, 16'h0000);
    check("wait three", cyc, 8);
    readyDelay <= 8'd5;
    cycle(20'h10000, 1'b0, 1'b0, 16'h0000);
    check("ext only", cyc > 5, 1'b1);
    readyDelay <= 8'd0;
    // move the block to memory page 0FF00 with both mode bits set
    cycle(20'h0FFFE, 1'b1, 1'b1, 16'hD0FF);
    cycle(20'h0FFFE, 1'b0, 1'b0, 16'h0000);
    check("reloc mem", rd, 16'hD0FF);
    check("mode bits", {slaveInterruptMode, escapeTrap}, 2'h3);
    cycle(20'h0FFFE, 1'b0, 1'b1, 16'h0000);
    check("io now ext", rd, 16'hFFFE ^ 16'hA5C3);
    cycle(20'h0FFFE, 1'b1, 1'b0, RELOC_RST);
    cycle(20'h0FFFE, 1'b0, 1'b1, 16'h0000);
    check("reloc back", rd, RELOC_RST);
    check("mode clear", {slaveInterruptMode, escapeTrap}, 2'h0);
    holdReq <= 1'b1;
    waitGrant(1'b1);
    check("grant lat", k, 4);
    check("granted float", {ctrlOe, adOe, upperOe, ale}, 4'h0);
    holdReq <= 1'b0;
    waitGrant(1'b0);
    repeat (2) @(posedge core_clk);
    check("drive again", ctrlOe, 1'b1);
    // a lock and then a started DMA transfer each hold the grant off
    for (j = 0; j < 2; j++) begin
      lockSeq <= (j == 0);
      dmaBusy <= (j == 1);
      holdReq <= 1'b1;
      repeat (12) @(posedge core_clk);
      check("grant held", busGrantOut, 1'b0);
      lockSeq <= 1'b0;
      dmaBusy <= 1'b0;
      waitGrant(1'b1);
      check("grant after", k <= 2, 1'b1);
      holdReq <= 1'b0;
      waitGrant(1'b0);
    end
    giveVerdict();
  end
endmodule
